// ### hdl/hpx_pkg.sv
// constants and helpers for the hot plug pci-x status and alternate decode block
// What this block does
// - pci-x command word is reserved, reads zero
// - status bits 31:21 reserved, read zero
// - status bit 20 reads 0, simple device
// - status bit 19 reads 0, no unexpected completions
// - status bit 18 reads 0, no split completions
// - status bits 17,16 read 1: 133MHz, 64-bit
// - status bits 15:8 report captured bus number
// - device number 1fh, function number 000b fixed
// - alternate base resets zero, bits 13:12 reserved
// - enable bit 15 claims 256-byte fecx_yz00 window
// - alternate window ignores header memory space enable
// - x,y,z nibbles compare address bits 19:8
// - bit 14 routes interrupt to active-low sci pin
// - working registers also decoded at base registers 10h/14h
package hpx_pkg;

  // ------------------------------------------------------------
  // configuration space byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] CFG_MEM_BASE_LOW  = 8'h10;  // memory_base_low
  localparam logic [7:0] CFG_MEM_BASE_HIGH = 8'h14;  // memory_base_high
  localparam logic [7:0] CFG_PCIX_CMD      = 8'h66;  // pcix_command_reserved
  localparam logic [7:0] CFG_PCIX_STATUS   = 8'h68;  // pcix_capability_status
  localparam logic [7:0] CFG_ALT_BASE      = 8'h80;  // alternate_window_base

  // ------------------------------------------------------------
  // capability status fixed fields
  // ------------------------------------------------------------
  localparam logic [10:0] STS_RESERVED   = 11'h000;  // bits 31:21
  localparam logic        STS_COMPLEX    = 1'h0;     // bit 20
  localparam logic        STS_UNEXP_SPLT = 1'h0;     // bit 19
  localparam logic        STS_SPLT_DISC  = 1'h0;     // bit 18
  localparam logic        STS_133MHZ     = 1'h1;     // bit 17
  localparam logic        STS_64BIT      = 1'h1;     // bit 16
  localparam logic [4:0]  STS_DEVICE_NUM = 5'h1f;    // bits 7:3
  localparam logic [2:0]  STS_FUNC_NUM   = 3'h0;     // bits 2:0
  localparam logic [15:0] PCIX_CMD_VALUE = 16'h0000; // all reserved

  // ------------------------------------------------------------
  // alternate_window_base layout
  // ------------------------------------------------------------
  localparam int          ALT_EN_BIT      = 15;        // window enable
  localparam int          ALT_ROUTE_BIT   = 14;        // acpi_event_route_enable
  localparam logic [15:0] ALT_WRITE_MASK  = 16'hcfff;  // 13:12 reserved
  localparam logic [15:0] ALT_RESET       = 16'h0000;
  localparam logic [11:0] ALT_PREFIX      = 12'hfec;   // address bits 31:20

  // ------------------------------------------------------------
  // memory base registers
  // ------------------------------------------------------------
  localparam logic [3:0]  MEM_BASE_TYPE_BITS = 4'h4;         // 64-bit, non-prefetchable
  localparam logic [31:0] MEM_BASE_LOW_MASK  = 32'hffffff00; // 256-byte window
  localparam logic [31:0] MEM_BASE_RESET     = 32'h00000000;
  localparam logic [7:0]  BUS_NUM_RESET   = 8'h00;

  // merge write data into a register under byte enables
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

endpackage

// ### hdl/hpx_win_decode.sv
// memory window decoder for the alternate and base-register windows
`timescale 1ns/100ps
`default_nettype none
module hpx_win_decode (
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        mem_req,       // memory cycle address valid
  input  wire logic [63:0] mem_addr,      // memory cycle address
  input  wire logic        mem_space_en,  // header memory space enable
  input  wire logic [15:0] alt_base,      // alternate_window_base value
  input  wire logic [63:0] mem_base,      // memory_base_high:low value
  output logic             win_hit,       // window claimed, one-cycle pulse
  output logic             win_alt,       // claim came from alternate window
  output logic [7:0]       win_offset     // register select inside window
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic       hit;
    logic       alt;
    logic [7:0] off;
  } hpx_dec_t;

  hpx_dec_t s_q;  // registered state
  hpx_dec_t s_d;  // next state
  logic     alt_match;  // alternate window compare
  logic     bar_match;  // base register compare

  // ------------------------------------------------------------
  // compare and register
  // ------------------------------------------------------------
  // alternate window: upper dword zero, fec prefix, x/y/z nibbles
  always_comb begin
    alt_match = alt_base[hpx_pkg::ALT_EN_BIT]
              && (mem_addr[63:32] == 32'h00000000)
              && (mem_addr[31:20] == hpx_pkg::ALT_PREFIX)
              && (mem_addr[19:16] == alt_base[11:8])
              && (mem_addr[15:12] == alt_base[7:4])
              && (mem_addr[11:8]  == alt_base[3:0]);
    bar_match = mem_space_en
              && (mem_addr[63:8] == mem_base[63:8]);
  end

  // next state; the alternate window does not look at mem_space_en
  always_comb begin
    s_d     = s_q;
    s_d.hit = mem_req && (alt_match || bar_match);
    s_d.alt = mem_req && alt_match;
    s_d.off = mem_addr[7:0];
  end

  // synchronous reset
  always_ff @(posedge clock) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign win_hit    = s_q.hit;
  assign win_alt    = s_q.alt;
  assign win_offset = s_q.off;

endmodule
`default_nettype wire

// ### hdl/hpx_cfg_regs.sv
// configuration registers, alternate window decode and interrupt routing
`timescale 1ns/100ps
`default_nettype none
module hpx_cfg_regs (
  input  wire logic        clock,
  input  wire logic        resetn,
  // configuration cycles, dword addressed with byte enables
  input  wire logic        cfg_req,        // config access, one-cycle pulse
  input  wire logic        cfg_write,      // 1 write, 0 read
  input  wire logic [7:0]  cfg_addr,       // byte address, bits 1:0 ignored
  input  wire logic [3:0]  cfg_be,         // byte enables
  input  wire logic [31:0] cfg_wdata,      // write data
  input  wire logic [7:0]  cfg_bus_num,    // bus number of this cycle
  output logic             cfg_ack,        // access done, one-cycle pulse
  output logic [31:0]      cfg_rdata,      // read data, valid with ack
  // memory cycles
  input  wire logic        mem_req,        // memory address valid
  input  wire logic [63:0] mem_addr,       // memory address
  input  wire logic        mem_space_en,   // header memory space enable
  output logic             win_hit,        // claim, one-cycle pulse
  output logic             win_alt,        // claim via alternate window
  output logic [7:0]       win_offset,     // register select
  // controller interrupt routing
  input  wire logic        hp_irq,         // unmasked controller interrupt level
  output logic             int_req,        // normal pin or msi request
  output logic             sci_n           // system control interrupt, active low
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [15:0] alt_base;   // alternate_window_base
    logic [7:0]  bus_num;    // captured bus number
    logic [31:0] base_low;   // memory_base_low
    logic [31:0] base_high;  // memory_base_high
    logic [31:0] rdata;      // read data
    logic        ack;        // access answer
    logic        irq;        // normal interrupt
    logic        sci_n;      // sci pin
  } hpx_cfg_t;

  hpx_cfg_t    s_q;          // registered state
  hpx_cfg_t    s_d;          // next state
  logic [7:0]  dw_addr;      // dword-aligned address
  logic [31:0] status_word;  // pcix_capability_status value
  logic [31:0] merged;       // write data merged for the hit dword

  // ------------------------------------------------------------
  // read values
  // ------------------------------------------------------------
  always_comb begin
    dw_addr     = {cfg_addr[7:2], 2'b00};
    status_word = {hpx_pkg::STS_RESERVED,
                   hpx_pkg::STS_COMPLEX,
                   hpx_pkg::STS_UNEXP_SPLT,
                   hpx_pkg::STS_SPLT_DISC,
                   hpx_pkg::STS_133MHZ,
                   hpx_pkg::STS_64BIT,
                   s_q.bus_num,
                   hpx_pkg::STS_DEVICE_NUM,
                   hpx_pkg::STS_FUNC_NUM};
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    s_d    = s_q;
    merged = 32'h00000000;
    s_d.ack = cfg_req;
    // bus number follows each config write seen by this function
    if (cfg_req && cfg_write) begin
      s_d.bus_num = cfg_bus_num;
    end
    if (cfg_req && cfg_write) begin
      case (dw_addr)
        hpx_pkg::CFG_ALT_BASE: begin
          // low half of the dword, reserved bits stay zero
          merged = hpx_pkg::merge_bytes({16'h0000, s_q.alt_base}, cfg_wdata, cfg_be);
          s_d.alt_base = merged[15:0] & hpx_pkg::ALT_WRITE_MASK;
        end
        hpx_pkg::CFG_MEM_BASE_LOW: begin
          merged = hpx_pkg::merge_bytes(s_q.base_low, cfg_wdata, cfg_be);
          s_d.base_low = merged & hpx_pkg::MEM_BASE_LOW_MASK;
        end
        hpx_pkg::CFG_MEM_BASE_HIGH: begin
          s_d.base_high = hpx_pkg::merge_bytes(s_q.base_high, cfg_wdata, cfg_be);
        end
        default: begin
          // read-only or unmapped: write is dropped
          merged = 32'h00000000;
        end
      endcase
    end
    // read mux; unmapped dwords read zero
    s_d.rdata = 32'h00000000;
    if (cfg_req && !cfg_write) begin
      case (dw_addr)
        hpx_pkg::CFG_PCIX_STATUS:   s_d.rdata = status_word;
        hpx_pkg::CFG_ALT_BASE:      s_d.rdata = {16'h0000, s_q.alt_base};
        hpx_pkg::CFG_MEM_BASE_LOW:  s_d.rdata = s_q.base_low | {28'h0000000,
                                                hpx_pkg::MEM_BASE_TYPE_BITS};
        hpx_pkg::CFG_MEM_BASE_HIGH: s_d.rdata = s_q.base_high;
        // command word sits in the upper half of the 64h dword
        {hpx_pkg::CFG_PCIX_CMD[7:2], 2'b00}:
          s_d.rdata = {hpx_pkg::PCIX_CMD_VALUE, 16'h0000};
        default:                    s_d.rdata = 32'h00000000;
      endcase
    end
    // interrupt routing checks the route bit before sending
    s_d.irq   = hp_irq && !s_q.alt_base[hpx_pkg::ALT_ROUTE_BIT];
    s_d.sci_n = !(hp_irq && s_q.alt_base[hpx_pkg::ALT_ROUTE_BIT]);
  end

  // ------------------------------------------------------------
  // registers, synchronous reset
  // ------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!resetn) begin
      s_q.alt_base  <= hpx_pkg::ALT_RESET;
      s_q.bus_num   <= hpx_pkg::BUS_NUM_RESET;
      s_q.base_low  <= hpx_pkg::MEM_BASE_RESET;
      s_q.base_high <= hpx_pkg::MEM_BASE_RESET;
      s_q.rdata     <= 32'h00000000;
      s_q.ack       <= 1'b0;
      s_q.irq       <= 1'b0;
      s_q.sci_n     <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ------------------------------------------------------------
  // window decoder
  // ------------------------------------------------------------
  hpx_win_decode u_dec (
    .clock        (clock),
    .resetn       (resetn),
    .mem_req      (mem_req),
    .mem_addr     (mem_addr),
    .mem_space_en (mem_space_en),
    .alt_base     (s_q.alt_base),
    .mem_base     ({s_q.base_high, s_q.base_low}),
    .win_hit      (win_hit),
    .win_alt      (win_alt),
    .win_offset   (win_offset)
  );

  assign cfg_ack   = s_q.ack;
  assign cfg_rdata = s_q.rdata;
  assign int_req   = s_q.irq;
  assign sci_n     = s_q.sci_n;

endmodule
`default_nettype wire

// ### testbench/hpx_cfg_regs_monitor.sv
// port assertions for the configuration register block
`timescale 1ns/100ps
`default_nettype none
module hpx_cfg_regs_monitor (
  input wire logic        clock,
  input wire logic        resetn,
  input wire logic        cfg_req,
  input wire logic        cfg_write,
  input wire logic [7:0]  cfg_addr,
  input wire logic [3:0]  cfg_be,
  input wire logic [31:0] cfg_wdata,
  input wire logic [7:0]  cfg_bus_num,
  input wire logic        cfg_ack,
  input wire logic [31:0] cfg_rdata,
  input wire logic        mem_req,
  input wire logic [63:0] mem_addr,
  input wire logic        mem_space_en,
  input wire logic        win_hit,
  input wire logic        win_alt,
  input wire logic [7:0]  win_offset,
  input wire logic        hp_irq,
  input wire logic        int_req,
  input wire logic        sci_n
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  wire logic       rd_sts = cfg_req && !cfg_write && cfg_addr[7:2] == 6'h1a;  // status read
  wire logic       rd_alt = cfg_req && !cfg_write && cfg_addr[7:2] == 6'h20;  // alt base read
  wire logic [7:0] low_b  = mem_addr[7:0];                                  // window select
  property p_cmd_zero;
    cfg_req && !cfg_write && cfg_addr[7:2] == 6'h19 |=> cfg_ack && cfg_rdata == 32'h0;
  endproperty
  a_cmd_zero: assert property (p_cmd_zero) else $error("command word not zero");
  property p_sts_fixed;
    rd_sts |=> cfg_rdata[31:16] == 16'h0003;
  endproperty
  a_sts_fixed: assert property (p_sts_fixed) else $error("status upper bits");
  property p_sts_ids;
    rd_sts |=> cfg_rdata[7:0] == 8'hf8;
  endproperty
  a_sts_ids: assert property (p_sts_ids) else $error("device or function number");
  property p_bus;
    cfg_req && cfg_write ##1 rd_sts |=> cfg_rdata[15:8] == $past(cfg_bus_num, 2);
  endproperty
  a_bus: assert property (p_bus) else $error("bus number not captured");
  property p_alt_rsv;
    rd_alt |=> cfg_rdata[31:16] == 16'h0 && cfg_rdata[13:12] == 2'h0;
  endproperty
  a_alt_rsv: assert property (p_alt_rsv) else $error("alt base reserved bits");
  property p_offset;
    mem_req |=> win_offset == $past(low_b);
  endproperty
  a_offset: assert property (p_offset) else $error("window offset");
  property p_prefix;
    mem_req && mem_addr[31:20] != 12'hfec |=> !win_alt;
  endproperty
  a_prefix: assert property (p_prefix) else $error("alt claim without prefix");
  property p_no_req;
    !mem_req |=> !win_hit;
  endproperty
  a_no_req: assert property (p_no_req) else $error("claim without request");
  property p_irq_idle;
    !hp_irq |=> !int_req && sci_n;
  endproperty
  a_irq_idle: assert property (p_irq_idle) else $error("interrupt without cause");
endmodule
bind hpx_cfg_regs hpx_cfg_regs_monitor hpx_cfg_regs_monitor_i (.*);
`default_nettype wire

// ### testbench/hpx_host_model.sv
// host bridge model issuing configuration and memory cycles
`timescale 1ns/100ps
`default_nettype none
module hpx_host_model (
  input  wire logic        clock,
  output var  logic        cfg_req,
  output var  logic        cfg_write,
  output var  logic [7:0]  cfg_addr,
  output var  logic [3:0]  cfg_be,
  output var  logic [31:0] cfg_wdata,
  output var  logic [7:0]  cfg_bus_num,
  output var  logic        mem_req,
  output var  logic [63:0] mem_addr,
  output var  logic        mem_space_en
);
  // all lines idle at time zero
  initial {cfg_req, cfg_write, cfg_addr, cfg_be, cfg_wdata, cfg_bus_num} = '0;
  initial {mem_req, mem_addr, mem_space_en} = '0;
  // one config request, taken at the next rising edge
  task automatic cfg(input logic w, input logic [7:0] a, input logic [3:0] be,
                     input logic [31:0] d, input logic [7:0] bus);
    #1 {cfg_req, cfg_write, cfg_addr, cfg_be, cfg_wdata, cfg_bus_num} = {1'b1, w, a, be, d, bus};
    mem_req = 1'b0;
    @(posedge clock);
  endtask
  // one memory address cycle
  task automatic mem(input logic [63:0] a, input logic m);
    #1 {mem_req, mem_addr, mem_space_en} = {1'b1, a, m};
    cfg_req = 1'b0;
    @(posedge clock);
  endtask
  // release: requests drop, cfg_wdata, cfg_addr and mem_addr show the inverse of their last value
  task automatic idle();
    #1 {cfg_req, mem_req} = 2'b00;
    {cfg_wdata, cfg_addr, mem_addr} = ~{cfg_wdata, cfg_addr, mem_addr};
    @(posedge clock);
  endtask
endmodule
`default_nettype wire

// ### testbench/hotplug_pcix_status_alt_decode_test.sv
// self-checking bench for the configuration register block
`timescale 1ns/100ps
`default_nettype none
module hotplug_pcix_status_alt_decode_test;
  logic        clock, resetn, hp_irq, cfg_req, cfg_write, mem_req, mem_space_en;
  logic        cfg_ack, win_hit, win_alt, int_req, sci_n, mem_due;
  logic [7:0]  cfg_addr, cfg_bus_num, win_offset;
  logic [3:0]  cfg_be;
  logic [31:0] cfg_wdata, cfg_rdata, r;
  logic [63:0] mem_addr;
  logic [15:0] alt;      // expected alternate base
  logic [31:0] rq[$];    // expected read data
  logic [9:0]  wq[$];    // expected hit, alt, offset
  int          bad_count, cmp_count;
  hpx_cfg_regs hpx_cfg_regs_i (.*);
  hpx_host_model hpx_host_model_i (.*);
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // ------------------------------------------------------------
  // compare and reporting
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t exp %h got %h", $time, e, g);
    end
  endtask
  // one compare task for each kind of result
  task automatic chk_rd(input logic [31:0] e);
    chk(e, cfg_rdata);
  endtask
  task automatic chk_win(input logic [9:0] e);
    chk({22'h0, e}, {22'h0, win_hit, win_alt, win_offset});
  endtask
  task automatic chk_irq(input logic [1:0] e);
    chk({30'h0, e}, {30'h0, int_req, sci_n});
  endtask
  task automatic end_of_test();
    // a result still owed means an answer never came
    if (rq.size() != 0 || wq.size() != 0) begin
      bad_count++;
      $display("MISMATCH t=%0t results still owed", $time);
    end
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // results are taken off the queues as they appear
  always @(posedge clock) mem_due <= mem_req;
  always @(negedge clock) begin
    if (cfg_ack === 1'b1) chk_rd(rq.pop_front());
    if (mem_due === 1'b1) chk_win(wq.pop_front());
  end
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    hpx_host_model_i.cfg(1'b0, a, 4'hf, $urandom, 8'h00);
  endtask
  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d,
                    input logic [7:0] bus);
    rq.push_back(32'h0);
    hpx_host_model_i.cfg(1'b1, a, be, d, bus);
  endtask
  task automatic mem(input logic [63:0] a, input logic m, input logic h, input logic al);
    wq.push_back({h, al, a[7:0]});
    hpx_host_model_i.mem(a, m);
  endtask
  // watchdog cuts a hang short
  initial begin
    #100000;
    bad_count++;
    end_of_test();
  end
  // main sequence
  initial begin
    {resetn, hp_irq, bad_count, cmp_count} = '0;
    void'($urandom(11));
    repeat (8) @(posedge clock);
    #1 resetn = 1'b1;
    @(posedge clock);
    rd(8'h80, 32'h0);
    rd(8'h64, 32'h0);
    rd(8'h68, 32'h0003_00f8);
    wr(8'h68, 4'hf, 32'hffff_ffff, 8'h5a);     // read-only place
    rd(8'h68, 32'h0003_5af8);
    rd(8'hfc, 32'h0);                          // unmapped place
    for (int i = 0; i < 6; i++) begin
      r = $urandom;
      alt = {1'b1, i[0], 2'b00, r[11:0]};
      wr(8'h80, 4'h3, {r[31:16], 1'b1, i[0], r[13:0]} | 32'h3000, r[23:16]);
      rd(8'h68, {16'h0003, r[23:16], 8'hf8});
      rd(8'h80, {16'h0, alt});
      mem({32'h0, 12'hfec, alt[11:0], r[7:0]}, r[0], 1'b1, 1'b1);
      mem({32'h0, 12'hfec, alt[11:0] ^ (12'h1 << (4 * (i % 3) + r[1:0])), r[7:0]},
          1'b0, 1'b0, 1'b0);
      mem({32'h0, 12'hfed, alt[11:0], r[7:0]}, 1'b0, 1'b0, 1'b0);
      hpx_host_model_i.idle();
      #1 hp_irq = i[1];
      @(posedge clock);
      @(negedge clock);
      chk_irq(alt[14] ? {1'b0, ~i[1]} : {i[1], 1'b1});
      @(posedge clock);
      wr(8'h80, 4'h3, {16'h0, 1'b0, alt[14:0]}, 8'h00);
      mem({32'h0, 12'hfec, alt[11:0], r[7:0]}, 1'b1, 1'b0, 1'b0);
    end
    // mid-run reset must return the alternate base to zero
    hpx_host_model_i.idle();
    #1 resetn = 1'b0;
    repeat (2) @(posedge clock);
    #1 resetn = 1'b1;
    @(posedge clock);
    rd(8'h80, 32'h0);
    wr(8'h10, 4'hf, 32'h1234_56ff, 8'h00);
    wr(8'h14, 4'hf, 32'h0000_0001, 8'h00);
    rd(8'h10, 32'h1234_5604);
    mem(64'h1_1234_5677, 1'b1, 1'b1, 1'b0);
    mem(64'h1_1234_5677, 1'b0, 1'b0, 1'b0);
    repeat (3) hpx_host_model_i.idle();
    end_of_test();
  end
endmodule
`default_nettype wire
